// ==== pkg/scc_pkg.sv ====
// Purpose: Shared constants and types of the standby and conversion control block
// Assumes: 125 MHz system clock, 8-bit register values
// Notes: Command codes double as register word indices on the parallel bus
package scc_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 125_000_000; // System clock rate
	localparam int unsigned CONV_TIME_MS = 60; // One channel conversion time
	localparam int unsigned CONV_CYCLES = CLK_HZ / 1000 * CONV_TIME_MS; // Cycles per channel
	localparam int unsigned TMO_TIME_MS = 30; // Bus lockup timeout, clock held low
	localparam int unsigned TMO_CYCLES = TMO_TIME_MS * (CLK_HZ / 1000); // Cycles of timeout
	localparam int CNT_W = 32; // Width of the long counters

	// ------------------------------------------------------------
	// Serial command codes and register indices
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_LOCAL = 8'h00; // Local temperature result
	localparam logic [7:0] CMD_REMOTE = 8'h01; // Remote temperature result
	localparam logic [7:0] CMD_STATUS = 8'h02; // Status byte
	localparam logic [7:0] CMD_CONFIG = 8'h03; // Configuration byte
	localparam logic [7:0] CMD_ONESHOT = 8'h0F; // Single conversion command
	localparam logic [6:0] SMB_ADDR_DEF = 7'h2A; // Default slave address

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int CFG_HALT_BIT = 6; // Conversion halt in configuration
	localparam int STAT_BUSY_BIT = 7; // Conversion in progress
	localparam int STAT_HWSTBY_BIT = 1; // Standby pin held low
	localparam logic [7:0] CFG_RST = 8'h00; // Configuration after reset
	localparam logic [7:0] TEMP_RST = 8'h00; // Result registers after reset
	localparam logic [7:0] PTR_RST = 8'h00; // Command pointer after reset

	// ------------------------------------------------------------
	// State encodings
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		C_IDLE = 2'b00,
		C_LOCAL = 2'b01,
		C_REMOTE = 2'b10
	} scc_conv_e;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_RX = 3'b001,
		S_RX_ACK = 3'b010,
		S_TX = 3'b011,
		S_TX_ACK = 3'b100
	} scc_smb_e;

endpackage

// ==== design/scc_smbus_slave.sv ====
// Purpose: Byte level two-wire slave with address match, ack and read-out
// Assumes: Pins sampled by two flops, bus far slower than the clock
// Notes: Open drain, only ever pulls data low
`timescale 1ns/1ns
module scc_smbus_slave
#(
	parameter logic [6:0] ADDR = scc_pkg::SMB_ADDR_DEF
)
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic bus_rst_i,
	input wire logic [7:0] tx_data_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic scl_o,
	output logic cmd_o,
	output logic wr_o,
	output logic [7:0] data_o
);
	import scc_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] scl_sy; // Bit 0 first stage, 1 second, 2 previous
		logic [2:0] sda_sy; // Same layout as the clock
		scc_smb_e st; // Bit level state
		logic [3:0] cnt; // Bits of current byte
		logic [7:0] sh; // Shift register
		logic [1:0] idx; // 0 address, 1 command, 2 data
		logic rd; // Read direction
		logic oe; // Pulling data low
		logic cmd; // Command byte pulse
		logic wr; // Data byte pulse
		logic [7:0] dat; // Last received command or data byte
	} scc_smb_s;

	scc_smb_s q;
	scc_smb_s d;
	logic scl; // Settled clock level
	logic sda; // Settled data level
	logic rise; // Clock rising
	logic fall; // Clock falling
	logic start; // Start or repeated start
	logic stop; // Stop condition

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// Only the second stage and its delayed copy feed any decision
	always_comb
	begin
		d = q;
		d.scl_sy = {q.scl_sy[1:0], scl_i};
		d.sda_sy = {q.sda_sy[1:0], sda_i};
		d.cmd = 1'b0;
		d.wr = 1'b0;
		scl = q.scl_sy[1];
		sda = q.sda_sy[1];
		rise = scl & ~q.scl_sy[2];
		fall = ~scl & q.scl_sy[2];
		start = scl & q.scl_sy[2] & q.sda_sy[2] & ~sda;
		stop = scl & q.scl_sy[2] & ~q.sda_sy[2] & sda;
		if (bus_rst_i)
		begin
			// Timeout frees the bus
			d.st = S_IDLE;
			d.oe = 1'b0;
		end
		else if (start)
		begin
			// Fresh frame, address byte next
			d.st = S_RX;
			d.cnt = 4'h0;
			d.idx = 2'h0;
			d.rd = 1'b0;
			d.oe = 1'b0;
		end
		else if (stop)
		begin
			d.st = S_IDLE;
			d.oe = 1'b0;
		end
		else
		begin
			unique case (q.st)
				S_IDLE:
				begin
					d.oe = 1'b0;
				end
				S_RX:
				begin
					// Sample on rise, act on the fall after bit eight
					if (rise)
					begin
						d.sh = {q.sh[6:0], sda};
						d.cnt = q.cnt + 4'h1;
					end
					else if (fall && q.cnt == 4'h8)
					begin
						if (q.idx == 2'h0)
						begin
							if (q.sh[7:1] == ADDR)
							begin
								d.rd = q.sh[0];
								d.oe = 1'b1;
								d.st = S_RX_ACK;
							end
							else
							begin
								d.st = S_IDLE;
							end
						end
						else
						begin
							d.dat = q.sh;
							d.cmd = (q.idx == 2'h1);
							d.wr = (q.idx == 2'h2);
							d.oe = 1'b1;
							d.st = S_RX_ACK;
						end
						d.idx = (q.idx == 2'h2) ? 2'h2 : q.idx + 2'h1;
					end
				end
				S_RX_ACK:
				begin
					// Ack ends on the fall; a read puts out its first bit there
					if (fall)
					begin
						if (q.rd)
						begin
							d.st = S_TX;
							d.oe = ~tx_data_i[7];
							d.sh = {tx_data_i[6:0], 1'b0};
							d.cnt = 4'h1;
						end
						else
						begin
							d.st = S_RX;
							d.oe = 1'b0;
							d.cnt = 4'h0;
						end
					end
				end
				S_TX:
				begin
					if (fall)
					begin
						if (q.cnt == 4'h8)
						begin
							d.oe = 1'b0;
							d.st = S_TX_ACK;
						end
						else
						begin
							d.oe = ~q.sh[7];
							d.sh = {q.sh[6:0], 1'b0};
							d.cnt = q.cnt + 4'h1;
						end
					end
				end
				S_TX_ACK:
				begin
					// Host ack means another byte, no ack ends the read
					if (rise)
					begin
						d.st = sda ? S_IDLE : S_RX_ACK;
					end
				end
				default:
				begin
					d.st = S_IDLE;
					d.oe = 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Idle bus reads high, so the sync stages start high
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			q <= '{scl_sy: 3'h7, sda_sy: 3'h7, st: S_IDLE, cnt: 4'h0, sh: 8'h00,
				idx: 2'h0, rd: 1'b0, oe: 1'b0, cmd: 1'b0, wr: 1'b0, dat: 8'h00};
		end
		else
		begin
			q <= d;
		end
	end

	assign sda_o = 1'b0; // Open drain level when enabled
	assign sda_oe_o = q.oe;
	assign scl_o = q.scl_sy[1];
	assign cmd_o = q.cmd;
	assign wr_o = q.wr;
	assign data_o = q.dat;

endmodule // scc_smbus_slave

// ==== design/scc_standby_ctrl.sv ====
// Purpose: Standby and conversion control of a two-channel temperature sensor
// Assumes: Converter results arrive on the system clock, bus reached over Wishbone
// Notes: Serial slave and parallel bus share one register map
`timescale 1ns/1ns
module scc_standby_ctrl
#(
	parameter int unsigned CONV_CYC = scc_pkg::CONV_CYCLES,
	parameter int unsigned TMO_CYC = scc_pkg::TMO_CYCLES,
	parameter logic [6:0] SMB_ADDR = scc_pkg::SMB_ADDR_DEF
)
(
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic standby_pin_n_i,
	input wire logic smb_scl_i,
	input wire logic smb_sda_i,
	output logic smb_sda_o,
	output logic smb_sda_oe_o,
	input wire logic [7:0] adc_local_i,
	input wire logic [7:0] adc_remote_i,
	output logic adc_enable_o,
	output logic adc_channel_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	import scc_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] pin_sy; // Standby pin synchroniser
		logic [7:0] cfg; // Configuration byte
		logic [7:0] ptr; // Last command byte other than the single conversion code
		logic [7:0] loc; // Local result
		logic [7:0] rem; // Remote result
		logic [7:0] loc_pend; // Local value until the pair completes
		scc_conv_e conv; // Conversion sequencer
		logic [CNT_W-1:0] cnt; // Time within a channel
		logic [CNT_W-1:0] tmo; // Clock low time
		logic bus_rst; // Timeout pulse to the slave
		logic adc_en; // Converter enable
		logic adc_ch; // 0 local, 1 remote
		logic ack; // Wishbone acknowledge
		logic [31:0] rdat; // Wishbone read data
	} scc_ctl_s;

	localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1); // Last cycle of a channel
	localparam logic [CNT_W-1:0] TMO_LAST = CNT_W'(TMO_CYC - 1); // Last cycle before reset

	scc_ctl_s q;
	scc_ctl_s d;
	logic [1:0] rst_sync_q; // Reset release stages
	logic rst_n; // Released reset
	logic smb_scl; // Settled serial clock
	logic smb_cmd; // Command byte pulse
	logic smb_wr; // Data byte pulse
	logic [7:0] smb_data; // Received byte
	logic [7:0] smb_tx; // Byte for a read
	logic hw_standby; // Pin held low
	logic halt; // Halt bit set
	logic standby; // Either standby form
	logic busy; // Conversion running
	logic halt_cmd; // Standby request from software
	logic shot_cmd; // Single conversion request
	logic wb_req; // New bus request
	logic [7:0] wb_code; // Word index of the request

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	// Assert at once, release two edges later to avoid recovery races
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rst_sync_q <= 2'b00;
		end
		else
		begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_q[1];

	// ------------------------------------------------------------
	// Register read decode, shared by both buses
	// ------------------------------------------------------------
	function automatic logic [7:0] scc_read(
		input logic [7:0] code,
		input scc_ctl_s s,
		input logic bsy,
		input logic hw
	);
		logic [7:0] v;
		v = 8'h00;
		unique case (code)
			CMD_LOCAL: v = s.loc;
			CMD_REMOTE: v = s.rem;
			CMD_STATUS:
			begin
				v[STAT_BUSY_BIT] = bsy;
				v[STAT_HWSTBY_BIT] = hw;
			end
			CMD_CONFIG: v = s.cfg;
			default: v = 8'h00; // Unmapped and write-only codes
		endcase
		return v;
	endfunction

	// ------------------------------------------------------------
	// Serial slave
	// ------------------------------------------------------------
	// Stays alive in standby; nothing here looks at the standby state
	scc_smbus_slave #(
		.ADDR(SMB_ADDR)
	) u_slave (
		.clock_i(clock_i),
		.rst_n_i(rst_n),
		.scl_i(smb_scl_i),
		.sda_i(smb_sda_i),
		.bus_rst_i(q.bus_rst),
		.tx_data_i(smb_tx),
		.sda_o(smb_sda_o),
		.sda_oe_o(smb_sda_oe_o),
		.scl_o(smb_scl),
		.cmd_o(smb_cmd),
		.wr_o(smb_wr),
		.data_o(smb_data)
	);

	// Receive byte reads whatever the last command selected
	assign smb_tx = scc_read(q.ptr, q, busy, hw_standby);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		d = q;
		d.bus_rst = 1'b0;
		d.ack = 1'b0;
		halt_cmd = 1'b0;
		shot_cmd = 1'b0;
		d.pin_sy = {q.pin_sy[0], standby_pin_n_i};
		hw_standby = ~q.pin_sy[1];
		halt = q.cfg[CFG_HALT_BIT];
		standby = hw_standby | halt;
		busy = (q.conv != C_IDLE);
		wb_code = {2'b00, wb_adr_i[7:2]};
		wb_req = wb_cyc_i & wb_stb_i & ~q.ack;

		// Serial command byte: single conversion or new pointer
		if (smb_cmd)
		begin
			if (smb_data == CMD_ONESHOT)
			begin
				shot_cmd = 1'b1;
			end
			else
			begin
				d.ptr = smb_data;
			end
		end

		// Serial data byte: only configuration is writable
		if (smb_wr && q.ptr == CMD_CONFIG)
		begin
			d.cfg = smb_data;
			halt_cmd = smb_data[CFG_HALT_BIT];
		end

		// Parallel bus, one cycle answer; it wins a same-cycle clash
		if (wb_req)
		begin
			d.ack = 1'b1;
			d.rdat = {24'h00_0000, scc_read(wb_code, q, busy, hw_standby)};
			if (wb_we_i && wb_sel_i[0])
			begin
				if (wb_code == CMD_CONFIG)
				begin
					d.cfg = wb_dat_i[7:0];
					halt_cmd = wb_dat_i[CFG_HALT_BIT];
				end
				else if (wb_code == CMD_ONESHOT)
				begin
					shot_cmd = 1'b1;
				end
			end
		end

		// Conversion sequencer; results move only on full completion
		unique case (q.conv)
			C_IDLE:
			begin
				// Pin low or a same-cycle halt write blocks every start
				if (!hw_standby && !halt_cmd && (!halt || shot_cmd))
				begin
					d.conv = C_LOCAL;
					d.cnt = '0;
					d.adc_en = 1'b1;
					d.adc_ch = 1'b0;
				end
				else
				begin
					d.adc_en = 1'b0;
				end
			end
			C_LOCAL,
			C_REMOTE:
			begin
				if (hw_standby || halt_cmd)
				begin
					// Abort drops the pending value, old results stay
					d.conv = C_IDLE;
					d.adc_en = 1'b0;
				end
				else if (q.cnt == CONV_LAST)
				begin
					d.cnt = '0;
					if (q.conv == C_LOCAL)
					begin
						d.loc_pend = adc_local_i;
						d.conv = C_REMOTE;
						d.adc_ch = 1'b1;
					end
					else
					begin
						// Idle one cycle so busy is seen low between passes
						d.loc = q.loc_pend;
						d.rem = adc_remote_i;
						d.conv = C_IDLE;
						d.adc_en = 1'b0;
						d.adc_ch = 1'b0;
					end
				end
				else
				begin
					d.cnt = q.cnt + CNT_W'(1);
				end
			end
			default:
			begin
				d.conv = C_IDLE;
				d.adc_en = 1'b0;
			end
		endcase

		// Lockup timeout on a held-low clock, never in standby
		if (standby || smb_scl)
		begin
			d.tmo = '0;
		end
		else if (q.tmo == TMO_LAST)
		begin
			d.tmo = '0;
			d.bus_rst = 1'b1;
		end
		else
		begin
			d.tmo = q.tmo + CNT_W'(1);
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// No standby path clears a result, configuration or pointer field, so data survives standby
	always_ff @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '{pin_sy: 2'b11, cfg: CFG_RST, ptr: PTR_RST, loc: TEMP_RST,
				rem: TEMP_RST, loc_pend: TEMP_RST, conv: C_IDLE, cnt: '0, tmo: '0,
				bus_rst: 1'b0, adc_en: 1'b0, adc_ch: 1'b0, ack: 1'b0,
				rdat: 32'h0000_0000};
		end
		else
		begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign adc_enable_o = q.adc_en;
	assign adc_channel_o = q.adc_ch;
	assign wb_dat_o = q.rdat;
	assign wb_ack_o = q.ack;

endmodule // scc_standby_ctrl

// ==== tb/scc_standby_ctrl_properties.sv ====
// Purpose: Port-level checks of the standby and conversion control block
// Assumes: One clock domain, reset active low
// Notes: Bound onto every instance of the top module
`timescale 1ns/1ns
module scc_standby_ctrl_chk
#(
	parameter int unsigned CONV_CYC = 20,
	parameter int unsigned TMO_CYC = 50
)
(
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic standby_pin_n_i,
	input wire logic smb_scl_i,
	input wire logic smb_sda_o,
	input wire logic smb_sda_oe_o,
	input wire logic adc_enable_o,
	input wire logic adc_channel_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o
);
	// ------------------------------------------------------------
	// Phase length counter
	// ------------------------------------------------------------
	int unsigned ph_q; // Cycles spent on one channel
	logic ch_q; // Channel seen last cycle
	// Restarts on a channel change or when the converter stops
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ph_q <= 0;
			ch_q <= 1'b0;
		end
		else
		begin
			ph_q <= (adc_enable_o && adc_channel_o == ch_q) ? ph_q + 1 : 0;
			ch_q <= adc_channel_o;
		end
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	property p_pin_halts;
		!standby_pin_n_i [*6] |-> !adc_enable_o;
	endproperty
	a_pin_halts: assert property (p_pin_halts) else $error("converter on while pin low");
	property p_halt_stops;
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i == 8'h0C
			&& wb_dat_i[6] |-> ##[1:4] !adc_enable_o;
	endproperty
	a_halt_stops: assert property (p_halt_stops) else $error("halt write did not stop");
	property p_chan_order;
		$rose(adc_channel_o) |-> $past(adc_enable_o, 2);
	endproperty
	a_chan_order: assert property (p_chan_order) else $error("remote before local");
	property p_phase_max;
		ph_q <= CONV_CYC + 2;
	endproperty
	a_phase_max: assert property (p_phase_max) else $error("phase too long");
	property p_sda_low_only;
		smb_sda_oe_o |-> !smb_sda_o;
	endproperty
	a_sda_low_only: assert property (p_sda_low_only) else $error("data driven high");
	property p_oe_scl_low;
		$changed(smb_sda_oe_o) |-> !smb_scl_i && !$past(smb_scl_i);
	endproperty
	a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved with clock high");
	property p_ack_next;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("no register answer");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("answer held too long");
	property p_ack_cause;
		wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
	property p_dat_upper;
		wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000;
	endproperty
	a_dat_upper: assert property (p_dat_upper) else $error("upper read bits set");
endmodule // scc_standby_ctrl_chk

bind scc_standby_ctrl scc_standby_ctrl_chk #(.CONV_CYC(CONV_CYC), .TMO_CYC(TMO_CYC)) chk_i (
	.clock_i(clock_i), .nrst_i(nrst_i), .standby_pin_n_i(standby_pin_n_i),
	.smb_scl_i(smb_scl_i), .smb_sda_o(smb_sda_o), .smb_sda_oe_o(smb_sda_oe_o),
	.adc_enable_o(adc_enable_o), .adc_channel_o(adc_channel_o), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

// ==== tb/scc_host_model.sv ====
// Purpose: Behavioural two-wire host issuing the four byte transactions
// Assumes: Pull-up on both lines, phases of Q system clocks
// Notes: stall holds the clock low mid-byte to provoke the lockup timer
`timescale 1ns/1ns
module scc_host_model
#(
	parameter logic [6:0] ADDR = 7'h2A,
	parameter int Q = 8
)
(
	input wire logic clock_i,
	input wire logic dev_oe_i,
	input wire logic dev_sda_i,
	output logic scl_o,
	output logic sda_o
);
	logic scl_q = 1'b1; // Clock idles high between frames
	logic pull_q = 1'b0; // Host pulls data low
	int naks = 0; // Bytes the device failed to acknowledge
	int stall = 0; // Extra low clock time inside each byte the host sends
	assign scl_o = scl_q;
	// Wired-and with pull-up: released line reads high
	assign sda_o = (pull_q || (dev_oe_i && !dev_sda_i)) ? 1'b0 : 1'b1;
	task automatic hc(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	// One bit: data set while clock low, sampled mid-high
	task automatic bitx(input logic b, output logic r);
		pull_q <= !b;
		hc(Q);
		scl_q <= 1'b1;
		hc(Q);
		r = sda_o;
		hc(Q);
		scl_q <= 1'b0;
		hc(Q);
	endtask
	// Start, also usable as repeated start
	task automatic start();
		pull_q <= 1'b0;
		hc(Q);
		scl_q <= 1'b1;
		hc(Q);
		pull_q <= 1'b1;
		hc(Q);
		scl_q <= 1'b0;
		hc(Q);
	endtask
	task automatic stop();
		pull_q <= 1'b1;
		hc(Q);
		scl_q <= 1'b1;
		hc(Q);
		pull_q <= 1'b0;
		hc(2 * Q);
	endtask
	task automatic tx(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bitx(d[i], r);
			if (i == 4)
				hc(stall);
		end
		bitx(1'b1, r);
		if (r !== 1'b0)
			naks++;
	endtask
	// Reads a byte and ends it with a not-acknowledge
	task automatic rx(output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(1'b1, r);
	endtask
	task automatic wr_byte(input logic [7:0] c, input logic [7:0] d);
		start();
		tx({ADDR, 1'b0});
		tx(c);
		tx(d);
		stop();
	endtask
	task automatic send_byte(input logic [7:0] c);
		start();
		tx({ADDR, 1'b0});
		tx(c);
		stop();
	endtask
	task automatic rd_byte(input logic [7:0] c, output logic [7:0] d);
		start();
		tx({ADDR, 1'b0});
		tx(c);
		start();
		tx({ADDR, 1'b1});
		rx(d);
		stop();
	endtask
	task automatic rcv_byte(output logic [7:0] d);
		start();
		tx({ADDR, 1'b1});
		rx(d);
		stop();
	endtask
endmodule // scc_host_model

// ==== tb/tb.sv ====
// Purpose: Self-checking bench of standby and conversion control
// Assumes: Short conversion and timeout counts set below
// Notes: Registers over classic Wishbone, serial side via host model
`timescale 1ns/1ns
module tb;
	import scc_pkg::*;
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic pin_n = 1'b1; // Hardware standby pin, high = run
	logic scl, sda, oe, sdo, en, ch, ack;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0] sel = 4'h0;
	logic [7:0] adr = 8'h00, t_loc = 8'h19, t_rem = 8'h7F, b;
	logic [31:0] wdat = 32'h0, rdat, q;
	int error_cnt = 0;
	int n_tests = 0;
	always #4 clock_i = ~clock_i;
	scc_standby_ctrl #(.CONV_CYC(20), .TMO_CYC(50)) scc_standby_ctrl_i (.clock_i(clock_i),
		.nrst_i(nrst_i), .standby_pin_n_i(pin_n), .smb_scl_i(scl), .smb_sda_i(sda),
		.smb_sda_o(sdo), .smb_sda_oe_o(oe), .adc_local_i(t_loc), .adc_remote_i(t_rem),
		.adc_enable_o(en), .adc_channel_o(ch), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
	scc_host_model #(.ADDR(SMB_ADDR_DEF)) scc_host_model_i (.clock_i(clock_i),
		.dev_oe_i(oe), .dev_sda_i(sdo), .scl_o(scl), .sda_o(sda));
	task automatic stop_test();
		$display("Checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			error_cnt++;
			$display("BAD %0t: saw %h want %h", $time, s, e);
		end
	endtask
	// Classic single cycle, held until the answer edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'h1;
		k = 0;
		do
		begin
			@(posedge clock_i);
			k++;
		end
		while (ack !== 1'b1 && k < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clock_i);
		if (k >= 20)
		begin
			error_cnt++;
			$display("BAD %0t: no bus answer", $time);
			stop_test();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		check(q, e);
	endtask
	// Bounded wait for the converter enable to reach a level
	task automatic wait_en(input logic v);
		int k;
		k = 0;
		while (en !== v && k < 400)
		begin
			@(posedge clock_i);
			k++;
		end
		if (k >= 400)
		begin
			error_cnt++;
			$display("BAD %0t: converter wait ran out", $time);
			stop_test();
		end
	endtask
	initial
	begin
		repeat (5) @(posedge clock_i);
		nrst_i <= 1'b1;
		repeat (5) @(posedge clock_i);
		rd(8'h0C, 32'h0);
		rd(8'h20, 32'h0);
		wait_en(1'b1);
		wait_en(1'b0);
		rd(8'h00, 32'h19);
		rd(8'h04, 32'h7F);
		wait_en(1'b1);
		rd(8'h08, 32'h80);
		t_loc <= 8'h55;
		t_rem <= 8'hAA;
		wb(1'b1, 8'h0C, 32'h40);
		repeat (60) @(posedge clock_i);
		check({31'h0, en}, 32'h0);
		rd(8'h00, 32'h19);
		rd(8'h0C, 32'h40);
		scc_host_model_i.send_byte(CMD_ONESHOT);
		repeat (100) @(posedge clock_i);
		check({31'h0, en}, 32'h0);
		rd(8'h00, 32'h55);
		rd(8'h04, 32'hAA);
		// Parallel single conversion in software standby: busy, then idle again
		wb(1'b1, 8'h3C, 32'h0);
		rd(8'h08, 32'h80);
		wait_en(1'b0);
		rd(8'h08, 32'h00);
		scc_host_model_i.wr_byte(CMD_CONFIG, 8'h00);
		wait_en(1'b1);
		scc_host_model_i.wr_byte(CMD_CONFIG, 8'h40);
		scc_host_model_i.rd_byte(CMD_REMOTE, b);
		check({24'h0, b}, 32'hAA);
		scc_host_model_i.rcv_byte(b);
		check({24'h0, b}, 32'hAA);
		rd(8'h0C, 32'h40);
		pin_n <= 1'b0;
		repeat (4) @(posedge clock_i);
		wb(1'b1, 8'h0C, 32'h0);
		scc_host_model_i.send_byte(CMD_ONESHOT);
		repeat (80) @(posedge clock_i);
		check({31'h0, en}, 32'h0);
		rd(8'h08, 32'h02);
		scc_host_model_i.stall = 100;
		scc_host_model_i.rd_byte(CMD_LOCAL, b);
		scc_host_model_i.stall = 0;
		check({24'h0, b}, 32'h55);
		t_loc <= 8'h01;
		t_rem <= 8'h02;
		pin_n <= 1'b1;
		wait_en(1'b1);
		repeat (10) @(posedge clock_i);
		pin_n <= 1'b0;
		repeat (80) @(posedge clock_i);
		check({31'h0, en}, 32'h0);
		rd(8'h00, 32'h55);
		rd(8'h04, 32'hAA);
		check(32'(scc_host_model_i.naks), 32'h0);
		stop_test();
	end
endmodule // tb
